// [design/ppd_port_ctrl.v]
// Functional notes
// - port k pull bit enables k input pulls
// - port e pull bit covers pins 7,4:0
// - port e pins 5,6 pulled only in reset
// - port b pull bit enables b input pulls
// - port a pull bit enables a input pulls
// - port a, b and e output pins never get a pull; port k pulls lag its direction by three edges
// - expanded modes hide registers, forward externally
// - reduced drive register always accessible when mapped
// - reduced drive applies whatever pin function
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "ppd_map.vh"

module ppd_port_ctrl #(
    parameter ADDR_W = 12
) (
    input  wire              pclk,
    input  wire              presetn,
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    input  wire [3:0]        pstrb,
    output reg  [31:0]       prdata,
    output reg               pready,
    output reg               pslverr,
    input  wire [7:0]        port_a_pin_in,
    input  wire [7:0]        port_b_pin_in,
    input  wire [7:0]        port_e_pin_in,
    input  wire [7:0]        port_k_direction,
    output reg  [7:0]        port_a_out,
    output reg  [7:0]        port_a_oe,
    output reg  [7:0]        port_b_out,
    output reg  [7:0]        port_b_oe,
    output reg  [7:0]        port_e_out,
    output reg  [7:0]        port_e_oe,
    output reg  [7:0]        port_a_pull,
    output reg  [7:0]        port_b_pull,
    output reg  [7:0]        port_e_pull,
    output reg  [7:0]        port_k_pull,
    output reg               reduced_drive_a,
    output reg               reduced_drive_b,
    output reg               reduced_drive_e,
    output reg               reduced_drive_k,
    output reg               ext_req,
    output reg  [ADDR_W-1:0] ext_addr,
    output reg               ext_write,
    output reg  [7:0]        ext_wdata,
    input  wire              ext_ack,
    input  wire [7:0]        ext_rdata
);

    // ------------------------------------------------------------------
    // state and registers
    // ------------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_EXT  = 2'b01;
    localparam ST_DONE = 2'b10;

    reg  [1:0] state;
    reg  [1:0] next_state;
    reg  [7:0] port_a_data;
    reg  [7:0] port_b_data;
    reg  [7:0] port_a_direction;
    reg  [7:0] port_b_direction;
    reg  [7:0] port_e_data;
    reg  [7:0] port_e_direction;
    reg  [7:0] port_e_assignment;
    reg  [7:0] operating_mode_select;
    reg  [7:0] pull_enable_control;
    reg  [7:0] reduced_drive_select;
    reg        in_reset;

    wire [7:0] pin_a_sync;
    wire [7:0] pin_b_sync;
    wire [7:0] pin_e_sync;
    wire [7:0] k_dir_sync;

    ppd_sync #(.WIDTH(32)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({port_a_pin_in, port_b_pin_in, port_e_pin_in, port_k_direction}),
        .dout    ({pin_a_sync, pin_b_sync, pin_e_sync, k_dir_sync})
    );

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    function is_single_chip;
        input [7:0] mode_reg;
        reg   [2:0] m;
        begin
            m = mode_reg[`PPD_MODE_MSB:`PPD_MODE_LSB];
            is_single_chip = (m == `PPD_MODE_NORMAL_SINGLE) ||
                             (m == `PPD_MODE_SPECIAL_SINGLE);
        end
    endfunction

    // pull drive for a port: requested only on pins that are inputs
    function [7:0] pull_for;
        input       enable;
        input [7:0] dir;
        begin
            pull_for = {8{enable}} & ~dir;
        end
    endfunction

    wire        word_ok  = (paddr[1:0] == 2'b00);
    wire [7:0]  reg_idx  = {2'b00, paddr[ADDR_W-1:2]} > 8'hff ? 8'hff :
                           paddr[9:2];
    wire        hi_zero  = (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});
    wire        mapped_cfg = is_single_chip(operating_mode_select);
    wire        cfg_reg  = (reg_idx == `PPD_IDX_PULL_CONTROL) ||
                           (reg_idx == `PPD_IDX_REDUCED_DRIVE);
    wire        forward  = cfg_reg && !mapped_cfg && hi_zero && word_ok;
    wire        known    = hi_zero && word_ok && (
                           reg_idx == `PPD_IDX_PORT_A_DATA ||
                           reg_idx == `PPD_IDX_PORT_B_DATA ||
                           reg_idx == `PPD_IDX_PORT_A_DIRECTION ||
                           reg_idx == `PPD_IDX_PORT_B_DIRECTION ||
                           reg_idx == `PPD_IDX_PORT_E_DATA ||
                           reg_idx == `PPD_IDX_PORT_E_DIRECTION ||
                           reg_idx == `PPD_IDX_PORT_E_ASSIGN ||
                           reg_idx == `PPD_IDX_MODE_SELECT ||
                           (cfg_reg && mapped_cfg));
    wire        setup    = psel && !penable && state == ST_IDLE;
    wire        do_write = setup && pwrite && known && pstrb[0];

    reg [7:0] read_value;

    always @* begin
        read_value = 8'h00;
        case (reg_idx)
            `PPD_IDX_PORT_A_DATA:
                read_value = (port_a_data & port_a_direction) |
                             (pin_a_sync & ~port_a_direction);
            `PPD_IDX_PORT_B_DATA:
                read_value = (port_b_data & port_b_direction) |
                             (pin_b_sync & ~port_b_direction);
            `PPD_IDX_PORT_A_DIRECTION: read_value = port_a_direction;
            `PPD_IDX_PORT_B_DIRECTION: read_value = port_b_direction;
            `PPD_IDX_PORT_E_DATA:
                read_value = (port_e_data & port_e_direction) |
                             (pin_e_sync & ~port_e_direction);
            `PPD_IDX_PORT_E_DIRECTION: read_value = port_e_direction;
            `PPD_IDX_PORT_E_ASSIGN:    read_value = port_e_assignment;
            `PPD_IDX_MODE_SELECT:      read_value = operating_mode_select;
            `PPD_IDX_PULL_CONTROL:
                read_value = pull_enable_control & `PPD_PULL_MASK;
            `PPD_IDX_REDUCED_DRIVE:
                read_value = reduced_drive_select & `PPD_DRIVE_MASK;
            default:                   read_value = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // apb handshake; forwarded accesses wait for the external bus
    // ------------------------------------------------------------------
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (setup && forward) begin
                    next_state = ST_EXT;
                end else if (setup) begin
                    next_state = ST_DONE;
                end
            ST_EXT:
                if (ext_ack) begin
                    next_state = ST_DONE;
                end
            ST_DONE:
                next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state          <= ST_IDLE;
            pready         <= 1'b0;
            pslverr        <= 1'b0;
            prdata         <= 32'h0000_0000;
            ext_req        <= 1'b0;
            ext_addr       <= {ADDR_W{1'b0}};
            ext_write      <= 1'b0;
            ext_wdata      <= 8'h00;
        end else begin
            state   <= next_state;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (setup && forward) begin
                ext_req   <= 1'b1;
                ext_addr  <= paddr;
                ext_write <= pwrite;
                ext_wdata <= pwdata[7:0];
            end
            if (state == ST_EXT && ext_ack) begin
                ext_req <= 1'b0;
                pready  <= 1'b1;
                prdata  <= ext_write ? 32'h0000_0000 : {24'h000000, ext_rdata};
                // the external byte goes straight to prdata, nothing else keeps it
            end
            if (setup && !forward) begin
                pready  <= 1'b1;
                pslverr <= !known;
                prdata  <= (known && !pwrite) ? {24'h000000, read_value} :
                           32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // writes land at the setup edge, so a local access needs no wait state;
    // forwarded addresses never reach these registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_a_data           <= `PPD_RST_ZERO;
            port_b_data           <= `PPD_RST_ZERO;
            port_a_direction      <= `PPD_RST_ZERO;
            port_b_direction      <= `PPD_RST_ZERO;
            port_e_data           <= `PPD_RST_ZERO;
            port_e_direction      <= `PPD_RST_ZERO;
            port_e_assignment     <= `PPD_RST_ZERO;
            operating_mode_select <= `PPD_RST_MODE;
            pull_enable_control   <= `PPD_RST_PULL;
            reduced_drive_select  <= `PPD_RST_DRIVE;
        end else if (do_write) begin
            case (reg_idx)
                `PPD_IDX_PORT_A_DATA:      port_a_data <= pwdata[7:0];
                `PPD_IDX_PORT_B_DATA:      port_b_data <= pwdata[7:0];
                `PPD_IDX_PORT_A_DIRECTION: port_a_direction <= pwdata[7:0];
                `PPD_IDX_PORT_B_DIRECTION: port_b_direction <= pwdata[7:0];
                `PPD_IDX_PORT_E_DATA:      port_e_data <= pwdata[7:0];
                `PPD_IDX_PORT_E_DIRECTION: port_e_direction <= pwdata[7:0];
                `PPD_IDX_PORT_E_ASSIGN:    port_e_assignment <= pwdata[7:0];
                `PPD_IDX_MODE_SELECT:
                    operating_mode_select <= pwdata[7:0] & `PPD_MODE_MASK;
                `PPD_IDX_PULL_CONTROL:
                    pull_enable_control <= pwdata[7:0] & `PPD_PULL_MASK;
                `PPD_IDX_REDUCED_DRIVE:
                    reduced_drive_select <= pwdata[7:0] & `PPD_DRIVE_MASK;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pin control outputs
    // ------------------------------------------------------------------
    // in_reset stays high for the first edge after release so the
    // reset-only pulls on port e pins 5 and 6 are seen from reset onward
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_reset        <= 1'b1;
            port_a_out      <= 8'h00;
            port_a_oe       <= 8'h00;
            port_b_out      <= 8'h00;
            port_b_oe       <= 8'h00;
            port_e_out      <= 8'h00;
            port_e_oe       <= 8'h00;
            port_a_pull     <= 8'h00;
            port_b_pull     <= 8'h00;
            port_e_pull     <= `PPD_PE_RESET_PULL_PINS;
            port_k_pull     <= 8'h00;
            reduced_drive_a <= 1'b0;
            reduced_drive_b <= 1'b0;
            reduced_drive_e <= 1'b0;
            reduced_drive_k <= 1'b0;
        end else begin
            in_reset    <= 1'b0;
            port_a_out  <= port_a_data;
            port_a_oe   <= port_a_direction;
            port_b_out  <= port_b_data;
            port_b_oe   <= port_b_direction;
            port_e_out  <= port_e_data;
            port_e_oe   <= port_e_direction;
            port_a_pull <= pull_for(pull_enable_control[`PPD_BIT_PORT_A],
                                    port_a_direction);
            port_b_pull <= pull_for(pull_enable_control[`PPD_BIT_PORT_B],
                                    port_b_direction);
            port_k_pull <= pull_for(pull_enable_control[`PPD_BIT_PORT_K],
                                    k_dir_sync);
            port_e_pull <= (pull_for(pull_enable_control[`PPD_BIT_PORT_E],
                                     port_e_direction) & `PPD_PE_PULL_PINS) |
                           ({8{in_reset}} & `PPD_PE_RESET_PULL_PINS);
            // drive strength follows the bit alone, whatever the pin carries
            reduced_drive_a <= reduced_drive_select[`PPD_BIT_PORT_A];
            reduced_drive_b <= reduced_drive_select[`PPD_BIT_PORT_B];
            reduced_drive_e <= reduced_drive_select[`PPD_BIT_PORT_E];
            reduced_drive_k <= reduced_drive_select[`PPD_BIT_PORT_K];
        end
    end

endmodule // ppd_port_ctrl

// [design/ppd_map.vh]
`ifndef PPD_MAP_VH
`define PPD_MAP_VH

// ----------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------------------------------------
`define PPD_IDX_PORT_A_DATA      8'h00
`define PPD_IDX_PORT_B_DATA      8'h01
`define PPD_IDX_PORT_A_DIRECTION 8'h02
`define PPD_IDX_PORT_B_DIRECTION 8'h03
`define PPD_IDX_PORT_E_DATA      8'h08
`define PPD_IDX_PORT_E_DIRECTION 8'h09
`define PPD_IDX_PORT_E_ASSIGN    8'h0a
`define PPD_IDX_MODE_SELECT      8'h0b
`define PPD_IDX_PULL_CONTROL     8'h0c
`define PPD_IDX_REDUCED_DRIVE    8'h0d

// ----------------------------------------------------------------------
// pull_enable_control / reduced_drive_select fields
// ----------------------------------------------------------------------
`define PPD_BIT_PORT_K           7
`define PPD_BIT_PORT_E           4
`define PPD_BIT_PORT_B           1
`define PPD_BIT_PORT_A           0
`define PPD_PULL_MASK            8'h93
`define PPD_DRIVE_MASK           8'h93
`define PPD_PE_PULL_PINS         8'h9f
`define PPD_PE_RESET_PULL_PINS   8'h60

// ----------------------------------------------------------------------
// mode register: bits 7:5 select the operating mode
// ----------------------------------------------------------------------
`define PPD_MODE_LSB             5
`define PPD_MODE_MSB             7
`define PPD_MODE_MASK            8'he0
`define PPD_MODE_NORMAL_SINGLE   3'h4
`define PPD_MODE_SPECIAL_SINGLE  3'h0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define PPD_RST_PULL             8'h90
`define PPD_RST_DRIVE            8'h00
`define PPD_RST_MODE             8'h80
`define PPD_RST_ZERO             8'h00

`endif

// [design/ppd_sync.v]
`timescale 1ns/1ps

// two-flop synchroniser for the external pin levels
module ppd_sync #(
    parameter WIDTH = 8
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] stage1;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= {WIDTH{1'b0}};
            dout   <= {WIDTH{1'b0}};
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule // ppd_sync

// [testbench/ppd_port_ctrl_chk.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// protocol and pin checks
// ----------------------------------------------------------------------
module ppd_port_ctrl_chk #(
    parameter ADDR_W = 12
) (
    input wire              pclk,
    input wire              presetn,
    input wire              psel,
    input wire              penable,
    input wire [ADDR_W-1:0] paddr,
    input wire              pready,
    input wire              pslverr,
    input wire [7:0]        port_a_pull,
    input wire [7:0]        port_a_oe,
    input wire [7:0]        port_b_pull,
    input wire [7:0]        port_b_oe,
    input wire [7:0]        port_e_pull,
    input wire [7:0]        port_e_oe,
    input wire              reduced_drive_a,
    input wire              reduced_drive_b,
    input wire              reduced_drive_e,
    input wire              reduced_drive_k,
    input wire              ext_req,
    input wire [ADDR_W-1:0] ext_addr,
    input wire              ext_ack
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // oe and pull may lag by an edge, so only a settled output is judged
    a_pull_a_out: assert property ((port_a_pull & port_a_oe & $past(port_a_oe)) == 8'h00)
        else $error("pull active on port a output");
    a_pull_b_out: assert property ((port_b_pull & port_b_oe & $past(port_b_oe)) == 8'h00)
        else $error("pull active on port b output");
    a_pull_e_out: assert property ((port_e_pull & port_e_oe & $past(port_e_oe) & 8'h9f) == 8'h00)
        else $error("pull active on port e output");
    a_e_rst_pull: assert property (disable iff (1'b0) !presetn |-> port_e_pull == 8'h60)
        else $error("port e reset pulls wrong");
    a_e_mid_pins: assert property (presetn && $past(presetn, 2) |-> port_e_pull[6:5] == 2'b00)
        else $error("port e pins 5 6 pulled after reset");
    a_local_ans: assert property (psel && !penable && paddr != 12'h030 && paddr != 12'h034 |=> pready)
        else $error("local access not answered at once");
    a_fwd_addr: assert property ($rose(ext_req) |-> ext_addr == 12'h030 || ext_addr == 12'h034)
        else $error("forwarded access to wrong address");
    a_fwd_hold: assert property (ext_req && !ext_ack |=> ext_req && $stable(ext_addr))
        else $error("forwarded request dropped early");
    a_fwd_done: assert property (ext_req && ext_ack |=> pready && !ext_req)
        else $error("forwarded access not completed");
    a_drive_hold: assert property (!$past(psel) && !$past(psel, 2) |->
        $stable({reduced_drive_a, reduced_drive_b, reduced_drive_e, reduced_drive_k}))
        else $error("drive select changed without access");
    a_bad_addr: assert property (psel && !penable && paddr == 12'h010 |=> pready && pslverr)
        else $error("reserved address not refused");

    cover property (ext_req && ext_ack);
    cover property (pready && pslverr);
    cover property ($rose(reduced_drive_k));
endmodule // ppd_port_ctrl_chk

// [testbench/port_pull_and_drive_control_test.sv]
`timescale 1ns/1ps
module port_pull_and_drive_control_test;
    reg         pclk, presetn, psel, penable, pwrite, ext_ack;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rdat;
    reg  [7:0]  a_in, b_in, e_in, k_dir, ext_rdata, v, adir, bdir, edir, fwd_d;
    reg  [7:0]  pull_m, drv_m, ad, bd, ed;
    reg         err, fwd_w;
    wire [31:0] prdata;
    wire        pready, pslverr, ext_req, ext_write, rd_a, rd_b, rd_e, rd_k;
    wire [7:0]  a_out, a_oe, b_out, b_oe, e_out, e_oe, a_pull, b_pull, e_pull, k_pull, ext_wdata;
    wire [11:0] ext_addr;
    integer     n_fail, checks_done, ext_wait, i;

    ppd_port_ctrl #(.ADDR_W(12)) i_ppd_port_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .port_a_pin_in(a_in), .port_b_pin_in(b_in), .port_e_pin_in(e_in),
        .port_k_direction(k_dir), .port_a_out(a_out), .port_a_oe(a_oe), .port_b_out(b_out),
        .port_b_oe(b_oe), .port_e_out(e_out), .port_e_oe(e_oe), .port_a_pull(a_pull),
        .port_b_pull(b_pull), .port_e_pull(e_pull), .port_k_pull(k_pull),
        .reduced_drive_a(rd_a), .reduced_drive_b(rd_b), .reduced_drive_e(rd_e),
        .reduced_drive_k(rd_k), .ext_req(ext_req), .ext_addr(ext_addr), .ext_write(ext_write),
        .ext_wdata(ext_wdata), .ext_ack(ext_ack), .ext_rdata(ext_rdata));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task chk(input [7:0] got, input [7:0] exp);
        begin
            checks_done = checks_done + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task summarize;
        begin
            $display("checks %0d mismatches %0d", checks_done, n_fail);
            if (n_fail == 0 && checks_done > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task apb(input w, input [11:0] a, input [7:0] d);
        integer n;
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= {24'h000000, d};
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge pclk);
                n = n + 1;
            end while (pready !== 1'b1 && n < 40);
            if (n >= 40) begin
                n_fail = n_fail + 1;
                $display("Error %0t: no pready", $time);
            end
            rdat = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // ------------------------------------------------------------------
    // external bus responder, 2-cycle wait before the first acknowledge, random 0 to 3 cycles before each later one
    // ------------------------------------------------------------------
    always @(posedge pclk) begin
        ext_ack <= 1'b0;
        if (ext_req && !ext_ack) begin
            if (ext_wait == 0) begin
                chk({ext_write, 7'h00}, {fwd_w, 7'h00});
                if (fwd_w) chk(ext_wdata, fwd_d);
                ext_ack <= 1'b1;
                ext_rdata <= $urandom;
                ext_wait <= $urandom % 4;
            end else
                ext_wait <= ext_wait - 1;
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        n_fail = n_fail + 1;
        $display("Error %0t: watchdog expired", $time);
        summarize;
    end

    initial begin
        n_fail = 0; checks_done = 0; ext_wait = 2; fwd_w = 0; fwd_d = 0;
        presetn = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        a_in = 0; b_in = 0; e_in = 0; k_dir = 0; ext_ack = 0; ext_rdata = 0;
        pull_m = 8'h90; drv_m = 8'h00;
        void'($urandom(82001));
        // a real falling edge, so the async reset acts before the first clock
        #1 presetn = 1'b0;
        repeat (3) @(posedge pclk);
        chk(e_pull, 8'h60);
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h030, 0); chk(rdat[7:0], pull_m);
        apb(0, 12'h010, 0); chk({err, rdat[6:0]}, 8'h80);
        for (i = 0; i < 12; i = i + 1) begin
            adir = $urandom; bdir = $urandom; edir = $urandom & 8'hfc;
            k_dir <= $urandom; a_in <= $urandom; b_in <= $urandom; e_in <= $urandom;
            v = $urandom; apb(1, 12'h030, v); pull_m = v & 8'h93;
            apb(1, 12'h008, adir); apb(1, 12'h00c, bdir); apb(1, 12'h024, edir);
            ad = $urandom;
            bd = $urandom;
            ed = $urandom;
            apb(1, 12'h000, ad);
            apb(1, 12'h004, bd);
            apb(1, 12'h020, ed);
            v = $urandom; apb(1, 12'h034, v); drv_m = v & 8'h93;
            repeat (4) @(posedge pclk);
            chk(a_pull, pull_m[0] ? ~adir : 8'h00);
            chk(b_pull, pull_m[1] ? ~bdir : 8'h00);
            chk(e_pull, pull_m[4] ? ~edir & 8'h9f : 8'h00);
            chk(k_pull, pull_m[7] ? ~k_dir : 8'h00);
            chk({rd_k, rd_e, rd_b, rd_a}, {drv_m[7], drv_m[4], drv_m[1:0]});
            chk(a_out, ad);
            chk(a_oe, adir);
            chk(b_out, bd);
            chk(b_oe, bdir);
            chk(e_out, ed);
            chk(e_oe, edir);
            apb(0, 12'h000, 0);
            chk(rdat[7:0], (ad & adir) | (a_in & ~adir));
            apb(0, 12'h004, 0);
            chk(rdat[7:0], (bd & bdir) | (b_in & ~bdir));
            apb(0, 12'h020, 0);
            chk(rdat[7:0], (ed & edir) | (e_in & ~edir));
            apb(0, 12'h030, 0); chk(rdat[7:0], pull_m);
            apb(0, 12'h034, 0); chk(rdat[7:0], drv_m);
        end
        // leave single-chip mode: both registers go to the external bus
        apb(1, 12'h02c, 8'h20);
        apb(0, 12'h030, 0); chk(rdat[7:0], ext_rdata);
        fwd_w = 1; fwd_d = $urandom;
        apb(1, 12'h034, fwd_d);
        chk({rd_k, rd_e, rd_b, rd_a}, {drv_m[7], drv_m[4], drv_m[1:0]});
        fwd_w = 0;
        apb(1, 12'h02c, 8'h80);
        apb(0, 12'h030, 0); chk(rdat[7:0], pull_m);
        apb(0, 12'h034, 0); chk(rdat[7:0], drv_m);
        // the special single-chip code keeps both registers local
        apb(1, 12'h02c, 8'h1f);
        apb(0, 12'h02c, 0);
        chk(rdat[7:0], 8'h00);
        apb(0, 12'h030, 0);
        chk(rdat[7:0], pull_m);
        // mid-run reset brings back defaults and the reset-only pulls
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(e_pull, 8'h60);
        chk({rd_k, rd_e, rd_b, rd_a}, 8'h00);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, 12'h030, 0);
        chk(rdat[7:0], 8'h90);
        apb(0, 12'h034, 0);
        chk(rdat[7:0], 8'h00);
        summarize;
    end
endmodule // port_pull_and_drive_control_test

bind ppd_port_ctrl ppd_port_ctrl_chk #(.ADDR_W(ADDR_W)) i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .port_a_pull(port_a_pull), .port_a_oe(port_a_oe),
    .port_b_pull(port_b_pull), .port_b_oe(port_b_oe), .port_e_pull(port_e_pull),
    .port_e_oe(port_e_oe), .reduced_drive_a(reduced_drive_a), .reduced_drive_b(reduced_drive_b),
    .reduced_drive_e(reduced_drive_e), .reduced_drive_k(reduced_drive_k),
    .ext_req(ext_req), .ext_addr(ext_addr), .ext_ack(ext_ack));
